//--- logic/tba_pkg.sv
`default_nettype none
package tba_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_CHAN  = 8'h04;
  localparam logic [7:0] A_PRE   = 8'h08;
  localparam logic [7:0] A_POST  = 8'h0c;
  localparam logic [7:0] A_STOP  = 8'h10;
  localparam logic [7:0] A_NIVL  = 8'h14;
  localparam logic [7:0] A_AIVL  = 8'h18;
  localparam logic [7:0] A_TRIG  = 8'h1c;
  localparam logic [7:0] A_TERM  = 8'h20;
  localparam logic [7:0] A_FMT   = 8'h24;
  localparam logic [7:0] A_SPOLL = 8'h28;
  localparam logic [7:0] A_USTR  = 8'h2c;
  localparam logic [7:0] A_DATA  = 8'h30;
  localparam logic [7:0] A_ISR   = 8'h34;
  localparam logic [7:0] A_IMR   = 8'h38;
  // ----------------------------------------------------------------
  // commands and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_RST   = 4'h1;
  localparam logic [3:0] OP_EXEC  = 4'h2;
  localparam logic [3:0] OP_CHAR  = 4'h3;
  localparam logic [3:0] OP_READ  = 4'h4;
  localparam logic [3:0] OP_QUERY = 4'h5;
  localparam logic [7:0] CH_TRIG  = 8'h40;
  localparam logic [3:0] SRC_CHAR = 4'h1;
  localparam logic [3:0] SRC_CNT  = 4'h8;
  localparam logic [3:0] TYPE_J   = 4'h1;
  localparam logic [3:0] TYPE_K   = 4'h2;
  localparam logic [3:0] TERM_LF  = 4'h8;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam int         POLL_RDY = 2;
  // ----------------------------------------------------------------
  // status string fields, 1-based columns
  // ----------------------------------------------------------------
  localparam int P_TOT = 9;
  localparam int W_TOT = 7;
  localparam int P_PRE = 18;
  localparam int W_PRE = 7;
  localparam int P_PST = 47;
  localparam int W_PST = 8;
  localparam int P_CUM = 77;
  localparam int W_CUM = 8;
  localparam int P_BLK = 86;
  localparam int STR_LEN = 87;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 8;
  localparam int TENTH_NS  = 100_000_000;
  localparam int TENTH_CYC = TENTH_NS / CLK_NS;
  localparam int INIT_CYC  = 16;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_BOOT  = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_PRE   = 5'b00100,
    ST_POST  = 5'b01000,
    ST_PSTOP = 5'b10000
  } tba_state_t;
  typedef struct packed {
    logic [31:0] tot;
    logic [31:0] pre;
    logic [31:0] pst;
    logic [31:0] cum;
  } tba_bcd_t;
  typedef struct packed {
    logic [3:0] ssrc;
    logic [3:0] psrc;
    logic       rearm;
    logic       sync;
  } tba_trig_t;

  function automatic logic [31:0] bcd_inc(logic [31:0] v);
    logic c;
    c = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (c) begin
        if (v[i*4 +: 4] == 4'h9) begin
          v[i*4 +: 4] = 4'h0;
        end else begin
          v[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return v;
  endfunction

  function automatic logic [7:0] term_char(logic [3:0] code);
    return (code == TERM_LF) ? CH_LF : 8'h00;
  endfunction
endpackage
`default_nettype wire

//--- logic/tba_core.sv
`timescale 1ns/1ps
`default_nettype none
module tba_core
  import tba_pkg::*;
#(
  parameter int NCH    = 48,
  parameter int NBLK   = 8,
  parameter int TENTHS = TENTH_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt and scan strobe
  output logic             irq,
  output logic             scan_pulse
);
  localparam int AW = $clog2(NBLK);

  typedef struct packed {
    tba_state_t           fsm;
    logic [5:0]           init;
    logic                 ready;
    logic [15:0]          pre_n;
    logic [15:0]          post_n;
    logic [15:0]          stop_n;
    logic [23:0]          nivl;
    logic [23:0]          aivl;
    logic [23:0]          ic;
    logic [23:0]          div;
    tba_trig_t            trig;
    logic [3:0]           sterm;
    logic [3:0]           bterm;
    logic [7:0]           fmt;
    logic [NCH-1:0][1:0]  chtype;
    logic [15:0]          sc;
    logic [15:0]          tot;
    tba_bcd_t             live;
    tba_bcd_t             snap;
    logic [NBLK-1:0][15:0] fifo;
    logic [AW-1:0]        wp;
    logic [AW-1:0]        rp;
    logic [AW:0]          nblk;
    logic                 upl;
    logic [15:0]          rem;
    logic [15:0]          sidx;
    logic [6:0]           sp;
    logic [3:0]           isr;
    logic [3:0]           imr;
    logic [31:0]          rdata;
    logic                 scan;
  } tba_st_t;

  tba_st_t s_r;
  tba_st_t s_nxt;
  tba_st_t s_rst;

  logic        wr;
  logic        rd;
  logic        hit;
  logic        tenth;
  logic        scan;
  logic        fire;
  logic [23:0] ivl;
  logic [23:0] hms;
  logic [3:0]  ev;
  logic [6:0]  nb;
  logic        done;
  logic        armed;

  // ----------------------------------------------------------------
  // status string character at a column
  // ----------------------------------------------------------------
  function automatic logic [7:0] ustr(logic [6:0] p, tba_bcd_t b, logic [6:0] n);
    int       q;
    logic [6:0] tens;
    logic [6:0] ones;
    logic [7:0] c;
    q    = int'(p);
    tens = n / 7'd10;
    ones = n % 7'd10;
    c    = CH_SP;
    if (q >= P_TOT && q < P_TOT + W_TOT) c = {4'h3, b.tot[4*(P_TOT+W_TOT-1-q) +: 4]};
    if (q >= P_PRE && q < P_PRE + W_PRE) c = {4'h3, b.pre[4*(P_PRE+W_PRE-1-q) +: 4]};
    if (q >= P_PST && q < P_PST + W_PST) c = {4'h3, b.pst[4*(P_PST+W_PST-1-q) +: 4]};
    if (q >= P_CUM && q < P_CUM + W_CUM) c = {4'h3, b.cum[4*(P_CUM+W_CUM-1-q) +: 4]};
    if (q == P_BLK) c = {4'h3, tens[3:0]};
    if (q == P_BLK + 1) c = {4'h3, ones[3:0]};
    return c;
  endfunction

  // ----------------------------------------------------------------
  // reset image, shared by rst and the reset command
  // ----------------------------------------------------------------
  always_comb begin
    s_rst       = '0;
    s_rst.fsm   = ST_BOOT;
    s_rst.sterm = TERM_LF;
    s_rst.bterm = TERM_LF;
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign hit    = (paddr[1:0] == 2'b00) && (paddr <= A_IMR);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign prdata = s_r.rdata;
  assign irq    = |(s_r.isr & s_r.imr);
  assign scan_pulse = s_r.scan;
  assign nb     = 7'(s_r.nblk);
  // boot counts as neither armed nor idle for the poll byte
  assign armed  = (s_r.fsm == ST_PRE) || (s_r.fsm == ST_POST) || (s_r.fsm == ST_PSTOP);
  // hours, minutes, seconds, tenths packed as bytes and a nibble
  assign hms    = 24'(pwdata[31:24]) * 24'd36000 + 24'(pwdata[23:16]) * 24'd600
                + 24'(pwdata[15:8]) * 24'd10 + 24'(pwdata[3:0]);

  // ----------------------------------------------------------------
  // scan pacing
  // ----------------------------------------------------------------
  // interval counter never stops, so a trigger without sync keeps its phase
  assign tenth = (s_r.div == 24'(TENTHS - 1));
  assign ivl   = (s_r.fsm == ST_POST) ? s_r.aivl : s_r.nivl;
  assign fire  = (ivl == 24'h0) || (s_r.ic + 24'h1 >= ivl);
  always_comb begin
    scan = 1'b0;
    if (s_r.fsm == ST_PRE || s_r.fsm == ST_POST || s_r.fsm == ST_PSTOP) begin
      // fast mode ignores the interval counter
      if (s_r.fsm == ST_POST && s_r.aivl == 24'h0) begin
        scan = 1'b1;
      end else begin
        scan = tenth & fire;
      end
    end
  end
  assign done = (s_r.fsm == ST_PSTOP) && scan && (s_r.sc + 16'h1 >= s_r.stop_n);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    ev         = 4'h0;
    s_nxt.scan = scan;
    s_nxt.div  = tenth ? 24'h0 : s_r.div + 24'h1;
    if (tenth) begin
      s_nxt.ic = fire ? 24'h0 : s_r.ic + 24'h1;
    end

    // read data captured in the setup cycle, so prdata is a flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        // only channels 1 to 16 read back, two bits each
        A_CHAN:  s_nxt.rdata = s_r.chtype[15:0];
        A_PRE:   s_nxt.rdata = 32'(s_r.pre_n);
        A_POST:  s_nxt.rdata = 32'(s_r.post_n);
        A_STOP:  s_nxt.rdata = 32'(s_r.stop_n);
        A_NIVL:  s_nxt.rdata = 32'(s_r.nivl);
        A_AIVL:  s_nxt.rdata = 32'(s_r.aivl);
        A_TRIG:  s_nxt.rdata = {22'h0, s_r.trig.sync, s_r.trig.rearm,
                                s_r.trig.psrc, s_r.trig.ssrc};
        A_TERM:  s_nxt.rdata = {24'h0, s_r.bterm, s_r.sterm};
        A_FMT:   s_nxt.rdata = 32'(s_r.fmt);
        A_SPOLL: s_nxt.rdata = {27'h0, s_r.fsm == ST_POST, s_r.fsm == ST_PSTOP,
                                s_r.ready, 1'b0, armed};
        A_USTR:  s_nxt.rdata = (s_r.sp > 7'(STR_LEN)) ? 32'(term_char(s_r.bterm))
                 : 32'(ustr(s_r.sp, (s_r.nblk != '0) ? s_r.snap : s_r.live, nb));
        A_DATA: begin
          if (s_r.upl) begin
            s_nxt.rdata = {(s_r.rem == 16'h1) ? term_char(s_r.bterm) : 8'h00,
                           term_char(s_r.sterm), s_r.sidx};
          end else begin
            s_nxt.rdata = 32'h0;
          end
        end
        A_ISR:   s_nxt.rdata = 32'(s_r.isr);
        A_IMR:   s_nxt.rdata = 32'(s_r.imr);
        default: s_nxt.rdata = 32'h0;
      endcase
    end

    // read side effects
    // clear only what the read returned; a setup-cycle event waits for the next read
    if (rd && paddr == A_ISR) s_nxt.isr = s_r.isr & ~s_r.rdata[3:0];
    if (rd && paddr == A_USTR && s_r.sp <= 7'(STR_LEN)) s_nxt.sp = s_r.sp + 7'h1;
    if (rd && paddr == A_DATA && s_r.upl && s_r.rem != 16'h0) begin
      s_nxt.rem  = s_r.rem - 16'h1;
      s_nxt.sidx = s_r.sidx + 16'h1;
      if (s_r.rem == 16'h1) begin
        // block fully read out, retire it
        s_nxt.upl  = 1'b0;
        s_nxt.rp   = s_r.rp + AW'(1);
        s_nxt.nblk = s_r.nblk - (AW+1)'(1);
      end
    end

    // ----------------------------------------------------------------
    // acquisition sequencer
    // ----------------------------------------------------------------
    if (scan) begin
      s_nxt.sc = s_r.sc + 16'h1;
      case (s_r.fsm)
        ST_PRE: begin
          // scans past the pre-trigger count are not retained
          if (s_r.tot < s_r.pre_n) begin
            s_nxt.tot      = s_r.tot + 16'h1;
            s_nxt.live.pre = bcd_inc(s_r.live.pre);
            s_nxt.live.tot = bcd_inc(s_r.live.tot);
          end
        end
        ST_POST: begin
          s_nxt.tot      = s_r.tot + 16'h1;
          s_nxt.live.pst = bcd_inc(s_r.live.pst);
          s_nxt.live.cum = bcd_inc(s_r.live.cum);
          s_nxt.live.tot = bcd_inc(s_r.live.tot);
          if (s_r.trig.psrc == SRC_CNT && s_r.sc + 16'h1 >= s_r.post_n) begin
            s_nxt.fsm = ST_PSTOP;
            s_nxt.sc  = 16'h0;
          end
        end
        ST_PSTOP: begin
          s_nxt.tot      = s_r.tot + 16'h1;
          s_nxt.live.cum = bcd_inc(s_r.live.cum);
          s_nxt.live.tot = bcd_inc(s_r.live.tot);
        end
        default: ;
      endcase
    end

    if (done) begin
      ev[2] = 1'b1;
      s_nxt.snap = '{tot: bcd_inc(s_r.live.tot), pre: s_r.live.pre,
                     pst: s_r.live.pst, cum: bcd_inc(s_r.live.cum)};
      if (s_r.nblk < (AW+1)'(NBLK)) begin
        s_nxt.fifo[s_r.wp] = s_r.tot + 16'h1;
        s_nxt.wp           = s_r.wp + AW'(1);
        s_nxt.nblk         = s_nxt.nblk + (AW+1)'(1);
      end else begin
        ev[3] = 1'b1; // buffer full, block lost
      end
      s_nxt.sc   = 16'h0;
      s_nxt.tot  = 16'h0;
      s_nxt.live = '0;
      s_nxt.fsm  = s_r.trig.rearm ? ST_PRE : ST_IDLE;
    end

    if (s_r.fsm == ST_BOOT) begin
      s_nxt.init = s_r.init + 6'h1;
      if (s_r.init == 6'(INIT_CYC - 1)) begin
        s_nxt.fsm   = ST_IDLE;
        s_nxt.ready = 1'b1;
        ev[0]       = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // register writes and commands
    // ----------------------------------------------------------------
    if (wr && s_r.fsm != ST_BOOT) begin
      case (paddr)
        A_CHAN: begin
          if (pwdata[19:16] == TYPE_J || pwdata[19:16] == TYPE_K) begin
            for (int i = 0; i < NCH; i++) begin
              if (i + 1 >= int'(pwdata[7:0]) && i + 1 <= int'(pwdata[15:8])) begin
                s_nxt.chtype[i] = pwdata[17:16];
              end
            end
          end
        end
        A_PRE:  s_nxt.pre_n  = pwdata[15:0];
        A_POST: s_nxt.post_n = pwdata[15:0];
        A_STOP: s_nxt.stop_n = pwdata[15:0];
        A_NIVL: s_nxt.nivl   = hms;
        A_AIVL: s_nxt.aivl   = hms;
        A_TRIG: begin
          s_nxt.trig = '{ssrc: pwdata[3:0], psrc: pwdata[7:4],
                         rearm: pwdata[8], sync: pwdata[9]};
          if (pwdata[9:0] == 10'h0) begin
            s_nxt.fsm = ST_IDLE;
          end
        end
        A_TERM: begin
          s_nxt.sterm = pwdata[3:0];
          s_nxt.bterm = pwdata[7:4];
        end
        A_FMT:  s_nxt.fmt = pwdata[7:0];
        A_IMR:  s_nxt.imr = pwdata[3:0];
        A_CMD: begin
          case (pwdata[11:8])
            OP_EXEC: begin
              if (s_r.trig.ssrc != 4'h0 && s_r.fsm == ST_IDLE) begin
                s_nxt.fsm  = ST_PRE;
                s_nxt.sc   = 16'h0;
                s_nxt.tot  = 16'h0;
                s_nxt.live = '0;
              end
            end
            OP_CHAR: begin
              if (pwdata[7:0] == CH_TRIG && s_r.trig.ssrc == SRC_CHAR
                  && s_r.fsm == ST_PRE) begin
                s_nxt.fsm = ST_POST;
                s_nxt.sc  = 16'h0;
                ev[1]     = 1'b1;
                // realign pacing only when sync is requested
                if (s_r.trig.sync) s_nxt.ic = 24'h0;
              end
            end
            OP_READ: begin
              // a second request during an upload is ignored
              if (s_r.nblk != '0 && !s_r.upl) begin
                s_nxt.upl  = 1'b1;
                s_nxt.rem  = s_r.fifo[s_r.rp];
                s_nxt.sidx = 16'h0;
              end
            end
            OP_QUERY: s_nxt.sp = 7'h1;
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // events set after clears so a set in the clearing cycle survives
    s_nxt.isr = s_nxt.isr | ev;

    if (wr && paddr == A_CMD && pwdata[11:8] == OP_RST) begin
      s_nxt = s_rst;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= s_rst;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- bench/tba_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tba_core_checker
  import tba_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        irq,
  input wire logic        scan_pulse
);
  // ----
  // helper state
  // ----
  logic       acc_w;
  logic       rcmd_w;
  logic [7:0] since_r;
  logic       exec_r;
  assign acc_w  = psel & penable & pwrite;
  assign rcmd_w = acc_w && paddr == A_CMD && pwdata[11:8] == OP_RST;
  // saturates so a long run never wraps back into the boot window
  always_ff @(posedge clock) begin
    if (rst || rcmd_w) begin
      since_r <= 8'h00;
      exec_r  <= 1'b0;
    end else begin
      if (since_r != 8'hff) since_r <= since_r + 8'h01;
      if (acc_w && paddr == A_CMD && pwdata[11:8] == OP_EXEC) exec_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  a_pready_phase: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  a_err_range: assert property (psel && penable && (paddr > 8'h38 || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("bad address not refused");
  a_err_quiet: assert property (psel && penable && paddr <= 8'h38 && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("good address refused");
  a_err_setup: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  a_bad_zero: assert property (psel && penable && !pwrite && paddr > 8'h38
    |-> prdata == 32'h0) else $error("bad read not zero");
  a_boot_busy: assert property (
    psel && penable && !pwrite && paddr == A_SPOLL && since_r < 8'd12 |-> !prdata[2])
    else $error("ready too early");
  a_boot_ready: assert property (
    psel && penable && !pwrite && paddr == A_SPOLL && since_r > 8'd20 |-> prdata[2])
    else $error("ready missing");
  a_reset_quiet: assert property ($fell(rst) |-> (!irq && !scan_pulse) [*8])
    else $error("activity after reset");
  a_idle_quiet: assert property (!exec_r && !$past(exec_r) |-> !scan_pulse)
    else $error("scan before execute");
  a_mask_off: assert property (acc_w && paddr == A_IMR && pwdata == 32'h0 |-> ##2 !irq)
    else $error("irq with mask clear");
endmodule
bind tba_core tba_core_checker chk (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .scan_pulse(scan_pulse)
);
`default_nettype wire

//--- bench/tba_host.sv
`timescale 1ns/1ps
`default_nettype none
module tba_host
  import tba_pkg::*;
(
  // clock
  input  wire logic        clock,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    xfer(1'b0, A_SPOLL, 32'h0);
    while (rdata[2] !== 1'b1 && n < 200) begin
      n++;
      xfer(1'b0, A_SPOLL, 32'h0);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/triggered_block_acquisition_test.sv
`timescale 1ns/1ps
`default_nettype none
module triggered_block_acquisition_test;
  import tba_pkg::*;
  logic        clock;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        scan_pulse;
  int          failures;
  int          num_checks;
  int          cyc;
  int          nscan;
  int          n0;
  logic [7:0]  ustr [1:87];
  tba_core #(.TENTHS(10)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scan_pulse(scan_pulse));
  tba_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial clock = 1'b0;
  always #4 clock = ~clock;
  // ----
  // timeout and scan counting
  // ----
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (scan_pulse === 1'b1) nscan <= nscan + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(logic [7:0] a);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  task automatic fld(int p, int w, int v);
    for (int i = 0; i < w; i++) begin
      chk("status digit", {24'h0, ustr[p+i]}, 32'h30 + (v / 10**(w-1-i)) % 10);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_boot();
    host.wait_ready();
    chk("ready bit", host.rdata[2], 1);
    rd(A_ISR);
    chk("ready event", host.rdata[0], 1);
    rd(A_ISR);
    chk("isr cleared", host.rdata, 0);
    rd(8'h3c);
    chk("unmapped err", host.rerr, 1);
    chk("unmapped data", host.rdata, 0);
  endtask
  task automatic t_config();
    wr(A_CHAN, 32'h0001_1001);
    wr(A_CHAN, 32'h0002_3021);
    wr(A_PRE, 32'h3);
    wr(A_POST, 32'h2);
    wr(A_STOP, 32'h2);
    wr(A_NIVL, 32'h3);
    wr(A_AIVL, 32'h0);
    wr(A_TRIG, 32'h181);
    wr(A_TERM, 32'h88);
    wr(A_IMR, 32'h4);
    n0 = nscan;
    wr(A_CMD, 32'h200);
    rd(A_SPOLL);
    chk("armed", host.rdata[0], 1);
    repeat (150) @(posedge clock);
    chk("normal pace", (nscan - n0 >= 4) && (nscan - n0 <= 6), 1);
  endtask
  task automatic t_trigger();
    int n;
    n = 0;
    n0 = nscan;
    wr(A_CMD, 32'h340);
    // second post scan is counted by the third edge; the first post-stop
    // scan, already due because sync is clear, is counted one edge later
    repeat (4) @(posedge clock);
    chk("fast post scans", nscan - n0, 2);
    rd(A_SPOLL);
    chk("post-stop state", host.rdata[4:3], 2'b01);
    while (irq !== 1'b1 && n < 200) begin
      n++;
      @(posedge clock);
    end
    chk("block irq", irq, 1);
    rd(A_ISR);
    chk("trig and block", host.rdata[2:1], 2'b11);
    repeat (2) @(posedge clock);
    chk("irq cleared", irq, 0);
    rd(A_SPOLL);
    chk("rearmed", {host.rdata[4:3], host.rdata[0]}, 3'b001);
  endtask
  task automatic t_status();
    wr(A_CMD, 32'h500);
    for (int i = 1; i <= 87; i++) begin
      rd(A_USTR);
      ustr[i] = host.rdata[7:0];
    end
    chk("filler", ustr[8], CH_SP);
    fld(9, 7, 7);
    fld(18, 7, 3);
    fld(47, 8, 2);
    fld(77, 8, 4);
    fld(86, 2, 1);
  endtask
  task automatic t_upload();
    wr(A_CMD, 32'h400);
    // one read per retained scan: three pre, two post, two post-stop
    for (int i = 0; i < 7; i++) begin
      rd(A_DATA);
      chk("scan index", host.rdata[15:0], 16'(i));
      chk("scan term", host.rdata[23:16], CH_LF);
      chk("block term", host.rdata[31:24], (i == 6) ? CH_LF : 8'h00);
    end
    rd(A_DATA);
    chk("block retired", host.rdata, 0);
  endtask
  task automatic t_disarm();
    wr(A_TRIG, 32'h0);
    rd(A_SPOLL);
    chk("disarmed", host.rdata[0], 0);
    wr(A_IMR, 32'h0);
    n0 = nscan;
    repeat (100) @(posedge clock);
    chk("no scans", nscan - n0, 0);
    chk("irq masked", irq, 0);
    rd(A_CHAN);
    chk("chan types", host.rdata, 32'h5555_5555);
    wr(A_FMT, 32'h1);
    rd(A_FMT);
    chk("format kept", host.rdata, 1);
    // reset command reinitialises, then ready returns
    wr(A_CMD, 32'h100);
    rd(A_SPOLL);
    chk("not ready", host.rdata[2], 0);
    chk("boot not armed", host.rdata[0], 0);
    host.wait_ready();
    chk("ready again", host.rdata[2], 1);
    rd(A_FMT);
    chk("format reset", host.rdata, 0);
    rd(A_CHAN);
    chk("chan reset", host.rdata, 0);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    nscan = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_boot();
    t_config();
    t_trigger();
    t_status();
    t_upload();
    t_disarm();
    final_report();
  end
endmodule
`default_nettype wire
